// ==== logic/dual_link_mux.sv ====
// Function
// - rgb line holds 2200/2640/2750 samples
// - split samples into upper ten, lower two
// - primary: all green, even blue/red
// - secondary: odd blue/red, all low bits
// - rgb low word: green, blue, red, reserved
// - bit 8 makes even parity
// - bit 9 inverts bit 8
// - reserved low-word bits are zero
// - primary order blue, green, red, green
// - secondary order blue, low, red, low
// - 4:2:2 chroma has half luma samples
// - 4:2:2 primary: luma, even chroma
// - 4:2:2 secondary: low bits plus auxiliary
// - even 4:2:2 low word: luma, cb, cr
// - odd 4:2:2 low word: luma only
// - 4:2:2 primary order cb, y, cr, y
// - 4:2:2 secondary alternates auxiliary, low word
// - 1920 active words per line
// - missing auxiliary defaults to 064
// - auxiliary never 000-003 or 3fc-3ff
`timescale 1ns/1ps
`default_nettype none

module dual_link_mux (
    input wire logic i_sys_clk,                            // word clock, 250 MHz
    input wire logic i_srst,                               // synchronous reset, high
    input wire logic i_fmt,                                // 0 rgb 4:4:4, 1 ycc 4:2:2
    input wire logic [1:0] i_rate,                         // rate family select
    input wire logic i_line_start,                         // restart line, one pulse
    input wire dual_link_mux_pkg::pair_t i_pair,           // even/odd sample pair
    output logic o_pair_take,                              // i_pair taken this edge
    output dual_link_mux_pkg::link_word_t o_link,          // registered link words
    output logic [11:0] o_word_idx,                        // word index of o_link
    output logic [10:0] o_sample_idx,                      // sample index of o_link
    output logic o_active                                  // word in active image
);

    dual_link_mux_pkg::pair_t pair_q;
    logic [11:0] word_q;
    logic [11:0] line_words;
    logic [11:0] chroma_samples;
    logic [1:0] phase;
    logic line_wrap;
    logic [9:0] lo_even_full;
    logic [9:0] lo_odd_full;
    logic [9:0] lo_odd_luma;
    logic [9:0] aux_even;
    logic [9:0] aux_odd;
    dual_link_mux_pkg::link_word_t link_d;

    // reserved bits driven zero
    // low-bit word: {~parity, parity, a, b, c, reserved}
    function automatic logic [9:0] low_word(input logic [1:0] a, input logic [1:0] b,
                                            input logic [1:0] c);
        logic [7:0] d;
        logic p;
        d = {a, b, c, 2'b00};
        p = ^d;
        return {~p, p, d};
    endfunction

    function automatic logic [9:0] aux_fix(input logic [9:0] v, input logic present);
        logic [9:0] r;
        r = present ? v : dual_link_mux_pkg::AUX_DEFAULT;
        if (r < dual_link_mux_pkg::AUX_MIN) begin
            r = dual_link_mux_pkg::AUX_MIN;
        end else if (r > dual_link_mux_pkg::AUX_MAX) begin
            r = dual_link_mux_pkg::AUX_MAX;
        end
        return r;
    endfunction

    always_comb begin
        unique case (i_rate)
            dual_link_mux_pkg::RATE_50_25: begin
                line_words = dual_link_mux_pkg::LINE_WORDS_50_25;
                chroma_samples = dual_link_mux_pkg::CHROMA_SAMPLES_50_25;
            end
            dual_link_mux_pkg::RATE_24: begin
                line_words = dual_link_mux_pkg::LINE_WORDS_24;
                chroma_samples = dual_link_mux_pkg::CHROMA_SAMPLES_24;
            end
            default: begin
                line_words = dual_link_mux_pkg::LINE_WORDS_60_30;
                chroma_samples = dual_link_mux_pkg::CHROMA_SAMPLES_60_30;
            end
        endcase
    end

    assign phase = word_q[1:0];
    assign line_wrap = (word_q >= line_words - 12'h001);
    // a new pair is needed after the last word of a pair or of the line
    assign o_pair_take = (phase == dual_link_mux_pkg::PHASE_D) || line_wrap || i_line_start;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            word_q <= 12'h000;
        end else if (i_line_start || line_wrap) begin
            word_q <= 12'h000;
        end else begin
            word_q <= word_q + 12'h001;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pair_q <= '0;
        end else if (o_pair_take) begin
            pair_q <= i_pair;
        end
    end

    // lower two bits into low words
    always_comb begin
        lo_even_full = low_word(pair_q.pix_even.c0[dual_link_mux_pkg::LOWER_MSB:0],
                                pair_q.pix_even.c1[dual_link_mux_pkg::LOWER_MSB:0],
                                pair_q.pix_even.c2[dual_link_mux_pkg::LOWER_MSB:0]);
        lo_odd_full = low_word(pair_q.pix_odd.c0[dual_link_mux_pkg::LOWER_MSB:0],
                               pair_q.pix_odd.c1[dual_link_mux_pkg::LOWER_MSB:0],
                               pair_q.pix_odd.c2[dual_link_mux_pkg::LOWER_MSB:0]);
        lo_odd_luma = low_word(pair_q.pix_odd.c0[dual_link_mux_pkg::LOWER_MSB:0],
                               2'b00, 2'b00);
        aux_even = aux_fix(pair_q.aux_even, pair_q.aux_present);
        aux_odd = aux_fix(pair_q.aux_odd, pair_q.aux_present);
    end

    // primary order, shared by both formats
    always_comb begin
        link_d = '0;
        unique case (phase)
            dual_link_mux_pkg::PHASE_A: begin
                link_d.prim = pair_q.pix_even.c1[11:2];
            end
            dual_link_mux_pkg::PHASE_B: begin
                link_d.prim = pair_q.pix_even.c0[11:2];
            end
            dual_link_mux_pkg::PHASE_C: begin
                link_d.prim = pair_q.pix_even.c2[11:2];
            end
            dual_link_mux_pkg::PHASE_D: begin
                link_d.prim = pair_q.pix_odd.c0[11:2];
            end
        endcase
        if (i_fmt == dual_link_mux_pkg::FMT_RGB444) begin
            unique case (phase)
                dual_link_mux_pkg::PHASE_A: begin
                    link_d.sec = pair_q.pix_odd.c1[11:2];
                end
                dual_link_mux_pkg::PHASE_B: begin
                    link_d.sec = lo_even_full;
                    link_d.sec_low = 1'b1;
                end
                dual_link_mux_pkg::PHASE_C: begin
                    link_d.sec = pair_q.pix_odd.c2[11:2];
                end
                dual_link_mux_pkg::PHASE_D: begin
                    link_d.sec = lo_odd_full;
                    link_d.sec_low = 1'b1;
                end
            endcase
        end else begin
            // secondary 4:2:2 alternates auxiliary and low word
            unique case (phase)
                dual_link_mux_pkg::PHASE_A: begin
                    link_d.sec = aux_even;
                    link_d.sec_aux = 1'b1;
                end
                dual_link_mux_pkg::PHASE_B: begin
                    link_d.sec = lo_even_full;
                    link_d.sec_low = 1'b1;
                end
                dual_link_mux_pkg::PHASE_C: begin
                    link_d.sec = aux_odd;
                    link_d.sec_aux = 1'b1;
                end
                dual_link_mux_pkg::PHASE_D: begin
                    link_d.sec = lo_odd_luma;
                    link_d.sec_low = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_link <= '0;
        end else begin
            o_link <= link_d;
        end
    end

    // position marks; sample index is word index halved
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_word_idx <= 12'h000;
            o_sample_idx <= 11'h000;
            o_active <= 1'b0;
        end else begin
            o_word_idx <= word_q;
            o_sample_idx <= word_q[11:1];
            o_active <= (word_q < dual_link_mux_pkg::ACTIVE_WORDS);
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    a_low_parity: assert property (o_link.sec_low |-> ^o_link.sec[8:0] == 1'b0)
        else $error("low word parity not even");
    a_parity_inverse: assert property (o_link.sec_low |-> o_link.sec[9] != o_link.sec[8])
        else $error("bit 9 not inverse of bit 8");
    a_reserved_zero: assert property (o_link.sec_low |-> o_link.sec[1:0] == 2'b00)
        else $error("reserved low bits not zero");
    a_odd_luma_only: assert property (
        $past(phase) == dual_link_mux_pkg::PHASE_D && $past(i_fmt) && !$past(i_srst)
        |-> o_link.sec[5:0] == 6'h00)
        else $error("odd 4:2:2 low word carries chroma");
    a_green_upper: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_B
        |-> o_link.prim == $past(pair_q.pix_even.c0[11:2]))
        else $error("primary green word wrong");
    a_rgb_low_map: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_B
        && $past(i_fmt) == 1'b0
        |-> o_link.sec[7:2] == {$past(pair_q.pix_even.c0[1:0]),
                                $past(pair_q.pix_even.c1[1:0]),
                                $past(pair_q.pix_even.c2[1:0])})
        else $error("rgb low word mapping wrong");
    a_odd_blue_sec: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_A
        && $past(i_fmt) == 1'b0
        |-> o_link.sec == $past(pair_q.pix_odd.c1[11:2]) && !o_link.sec_low)
        else $error("secondary odd blue word wrong");
    a_aux_range: assert property (
        o_link.sec_aux |-> o_link.sec >= dual_link_mux_pkg::AUX_MIN
        && o_link.sec <= dual_link_mux_pkg::AUX_MAX)
        else $error("auxiliary word out of range");
    a_aux_default: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_A && $past(i_fmt)
        && !$past(pair_q.aux_present) |-> o_link.sec == dual_link_mux_pkg::AUX_DEFAULT)
        else $error("auxiliary default not 064");
    a_line_wrap: assert property (
        word_q == line_words - 12'h001 && !i_line_start ##1 !i_line_start
        |-> word_q == 12'h000 ##1 word_q == 12'h001)
        else $error("word counter did not wrap at line end");
    a_line_len: assert property ($stable(i_rate) |-> word_q < line_words)
        else $error("word index beyond line length");
    a_active_count: assert property (
        o_word_idx == 12'h77f ##1 o_word_idx == 12'h780 |-> $past(o_active) && !o_active)
        else $error("active region not 1920 words");

    a_blue_upper: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_A
        |-> o_link.prim == $past(pair_q.pix_even.c1[11:2]))
        else $error("primary even blue word wrong");
    a_red_upper: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_C
        |-> o_link.prim == $past(pair_q.pix_even.c2[11:2]))
        else $error("primary even red word wrong");
    a_odd_luma_prim: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_D
        |-> o_link.prim == $past(pair_q.pix_odd.c0[11:2]))
        else $error("primary odd luma word wrong");
    a_odd_red_sec: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_C
        && $past(i_fmt) == 1'b0
        |-> o_link.sec == $past(pair_q.pix_odd.c2[11:2]) && !o_link.sec_low)
        else $error("secondary odd red word wrong");
    a_ycc_low_map: assert property (
        !$past(i_srst) && $past(phase) == dual_link_mux_pkg::PHASE_B
        && $past(i_fmt) == 1'b1
        |-> o_link.sec[7:2] == {$past(pair_q.pix_even.c0[1:0]),
                                $past(pair_q.pix_even.c1[1:0]),
                                $past(pair_q.pix_even.c2[1:0])})
        else $error("4:2:2 low word mapping wrong");
    a_aux_slot: assert property (
        !$past(i_srst) && $past(i_fmt) && !$past(phase[0])
        |-> o_link.sec_aux && !o_link.sec_low)
        else $error("4:2:2 auxiliary slot wrong");
    a_ycc_low_slot: assert property (
        !$past(i_srst) && $past(i_fmt) && $past(phase[0])
        |-> o_link.sec_low && !o_link.sec_aux)
        else $error("4:2:2 low word slot wrong");
    a_chroma_count: assert property (
        $stable(i_rate) |-> {1'b0, word_q[11:1]} < chroma_samples)
        else $error("chroma index beyond half line");

    c_rgb_quad: cover property (!i_fmt && phase == dual_link_mux_pkg::PHASE_D);
    c_ycc_quad: cover property (i_fmt && phase == dual_link_mux_pkg::PHASE_D);
    c_line_24: cover property (i_rate == dual_link_mux_pkg::RATE_24 && line_wrap);
    c_restart: cover property (i_line_start && word_q != 12'h000);
    c_aux_clamp: cover property (o_link.sec_aux && o_link.sec == dual_link_mux_pkg::AUX_MAX);

endmodule

`default_nettype wire

// ==== logic/dual_link_mux_pkg.sv ====
package dual_link_mux_pkg;

    // line lengths in words per link, one per rate family
    localparam logic [11:0] LINE_WORDS_60_30 = 12'h898;  // 2200
    localparam logic [11:0] LINE_WORDS_50_25 = 12'ha50;  // 2640
    localparam logic [11:0] LINE_WORDS_24 = 12'habe;     // 2750
    // chroma samples per line in the 4:2:2 format
    localparam logic [11:0] CHROMA_SAMPLES_60_30 = 12'h44c;  // 1100
    localparam logic [11:0] CHROMA_SAMPLES_50_25 = 12'h528;  // 1320
    localparam logic [11:0] CHROMA_SAMPLES_24 = 12'h55f;     // 1375
    localparam logic [11:0] ACTIVE_WORDS = 12'h780;          // 1920

    localparam logic [9:0] AUX_DEFAULT = 10'h064;
    localparam logic [9:0] AUX_MIN = 10'h004;
    localparam logic [9:0] AUX_MAX = 10'h3fb;

    localparam int UPPER_MSB = 11;
    localparam int UPPER_LSB = 2;
    localparam int LOWER_MSB = 1;
    localparam int PARITY_POS = 8;
    localparam int INV_PARITY_POS = 9;

    localparam logic [1:0] PHASE_A = 2'h0;
    localparam logic [1:0] PHASE_B = 2'h1;
    localparam logic [1:0] PHASE_C = 2'h2;
    localparam logic [1:0] PHASE_D = 2'h3;

    typedef enum logic [1:0] {
        RATE_60_30 = 2'b00,
        RATE_50_25 = 2'b01,
        RATE_24 = 2'b10
    } rate_t;

    typedef enum logic {
        FMT_RGB444 = 1'b0,
        FMT_YCC422 = 1'b1
    } fmt_t;

    // c0 = green or luma, c1 = blue or blue-difference, c2 = red or red-difference
    typedef struct packed {
        logic [11:0] c0;
        logic [11:0] c1;
        logic [11:0] c2;
    } pixel_t;

    typedef struct packed {
        pixel_t pix_even;
        pixel_t pix_odd;
        logic [9:0] aux_even;
        logic [9:0] aux_odd;
        logic aux_present;
    } pair_t;

    typedef struct packed {
        logic [9:0] prim;
        logic [9:0] sec;
        logic sec_low;
        logic sec_aux;
    } link_word_t;

endpackage

// ==== bench/link_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none

module link_receiver (
    input wire logic i_sys_clk,                    // word clock
    input wire logic i_srst,                       // synchronous reset, high
    input wire dual_link_mux_pkg::link_word_t i_link,  // words from the mux
    output logic o_low_ok                          // all low words well formed
);
    logic low_ok_q;
    logic [9:0] w;
    assign w = i_link.sec;
    assign o_low_ok = low_ok_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            low_ok_q <= 1'b1;
        end else if (i_link.sec_low && (^w[8:0] || w[9] == w[8] || w[1:0] != 2'h0)) begin
            low_ok_q <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ==== bench/dual_link_12bit_sample_mux_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module dual_link_12bit_sample_mux_tb_top;
    typedef struct packed {
        logic fmt;
        dual_link_mux_pkg::pair_t pair;
    } row_t;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_fmt = 1'b0;
    logic [1:0] i_rate = 2'h0;
    logic i_line_start = 1'b0;
    dual_link_mux_pkg::pair_t i_pair = '0;
    logic o_pair_take;
    dual_link_mux_pkg::link_word_t o_link;
    logic [11:0] o_word_idx;
    logic [10:0] o_sample_idx;
    logic o_active;
    logic low_ok;
    logic [11:0] n;
    logic [11:0] act;
    logic [11:0] lens [4] = '{dual_link_mux_pkg::LINE_WORDS_60_30,
        dual_link_mux_pkg::LINE_WORDS_50_25, dual_link_mux_pkg::LINE_WORDS_24,
        dual_link_mux_pkg::LINE_WORDS_60_30};
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    row_t rows [6];

    always #2 i_sys_clk = ~i_sys_clk;

    dual_link_mux u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_fmt(i_fmt),
        .i_rate(i_rate), .i_line_start(i_line_start), .i_pair(i_pair),
        .o_pair_take(o_pair_take), .o_link(o_link), .o_word_idx(o_word_idx),
        .o_sample_idx(o_sample_idx), .o_active(o_active));
    link_receiver u_rx (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_link(o_link),
        .o_low_ok(low_ok));

    task automatic report_and_stop();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("unexpected at %0t: run too long", $time);
            report_and_stop();
        end
    end

    function automatic logic [9:0] low_w(input logic [1:0] a, input logic [1:0] b,
        input logic [1:0] c);
        logic p;
        p = ^{a, b, c};
        return {~p, p, a, b, c, 2'h0};
    endfunction

    function automatic logic [9:0] aux_w(input logic [9:0] a, input logic present);
        if (!present) return 10'h064;
        if (a < 10'h004) return 10'h004;
        if (a > 10'h3fb) return 10'h3fb;
        return a;
    endfunction

    function automatic dual_link_mux_pkg::link_word_t exp_word(input logic y,
        input dual_link_mux_pkg::pair_t r, input logic [1:0] ph);
        dual_link_mux_pkg::pixel_t e;
        dual_link_mux_pkg::pixel_t o;
        e = r.pix_even;
        o = r.pix_odd;
        case (ph)
            2'h0: return {e.c1[11:2], y ? aux_w(r.aux_even, r.aux_present) : o.c1[11:2], 1'b0, y};
            2'h1: return {e.c0[11:2], low_w(e.c0[1:0], e.c1[1:0], e.c2[1:0]), 2'h2};
            2'h2: return {e.c2[11:2], y ? aux_w(r.aux_odd, r.aux_present) : o.c2[11:2], 1'b0, y};
            default: return {o.c0[11:2],
                low_w(o.c0[1:0], y ? 2'h0 : o.c1[1:0], y ? 2'h0 : o.c2[1:0]), 2'h2};
        endcase
    endfunction

    task automatic send(input logic fmt, input dual_link_mux_pkg::pair_t p,
        input dual_link_mux_pkg::pair_t q);
        @(negedge i_sys_clk);
        i_fmt = fmt;
        @(negedge i_sys_clk);
        i_line_start = 1'b1;
        i_pair = p;
        #1;
        chk({21'h0, o_pair_take}, 22'h1, "take");
        @(negedge i_sys_clk);
        i_line_start = 1'b0;
        i_pair = q;
        for (int k = 0; k < 8; k++) begin
            @(negedge i_sys_clk);
            chk(o_link, exp_word(fmt, k < 4 ? p : q, 2'(k)), "link");
            chk({10'h0, o_word_idx}, 22'(k), "word index");
            chk({10'h0, o_sample_idx, o_active}, {10'h0, 11'(k / 2), 1'b1}, "sample");
            chk({21'h0, o_pair_take}, {21'h0, (k % 4 == 2)}, "take");
        end
        $display("test quad fmt %0d done", fmt);
    endtask

    initial begin
        rows = '{
            '{1'b0, '{'{12'h5a7, 12'hc3e, 12'h019}, '{12'h9f2, 12'h36d, 12'hae4},
                10'h155, 10'h2aa, 1'b1}},
            '{1'b0, '{'{12'hfff, 12'h000, 12'haaa}, '{12'h555, 12'hfff, 12'h001},
                10'h000, 10'h000, 1'b0}},
            '{1'b1, '{'{12'h123, 12'h456, 12'h789}, '{12'habc, 12'hdef, 12'hffe},
                10'h155, 10'h2aa, 1'b1}},
            '{1'b1, '{'{12'h802, 12'h403, 12'h201}, '{12'he01, 12'h000, 12'h000},
                10'h002, 10'h3fe, 1'b1}},
            '{1'b1, '{'{12'h7ff, 12'h800, 12'h3ff}, '{12'hc00, 12'hfff, 12'hfff},
                10'h3fc, 10'h003, 1'b1}},
            '{1'b1, '{'{12'h001, 12'h002, 12'h003}, '{12'h803, 12'h111, 12'h222},
                10'h3ff, 10'h000, 1'b0}}};
        repeat (16) @(negedge i_sys_clk);
        chk(o_link, 22'h0, "reset link");
        i_srst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            send(rows[i].fmt, rows[i].pair, rows[(i + 1) % 6].pair);
        end
        for (int rt = 0; rt < 4; rt++) begin
            @(negedge i_sys_clk);
            i_rate = 2'(rt);
            i_line_start = 1'b1;
            @(negedge i_sys_clk);
            i_line_start = 1'b0;
            @(negedge i_sys_clk);
            n = 12'h0;
            act = 12'h0;
            do begin
                act += {11'h0, o_active === 1'b1};
                n++;
                @(negedge i_sys_clk);
            end while (o_word_idx !== 12'h0 && n < 12'hbb8);
            chk({10'h0, n}, {10'h0, lens[rt]}, "line length");
            chk({10'h0, act}, {10'h0, dual_link_mux_pkg::ACTIVE_WORDS}, "active");
            $display("test line rate %0d done", rt);
        end
        chk({21'h0, low_ok}, 22'h1, "low words");
        @(negedge i_sys_clk);
        i_srst = 1'b1;
        i_fmt = 1'b1;
        @(negedge i_sys_clk);
        chk(o_link, 22'h0, "reset link");
        chk({10'h0, o_word_idx}, 22'h0, "reset index");
        i_srst = 1'b0;
        @(negedge i_sys_clk);
        chk(o_link, {10'h000, 10'h064, 2'h1}, "first word");
        $display("test reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
